// >>> src/ums_pkg.sv
// Behaviour
// - A character is start bit, eight data bits LSB first, one stop bit.
// - Accepted reception stores data byte and received stop bit.
// - Writing the data buffer starts a new transmission; the code drops a write made while busy.
// - Transmit-done flag sets when the stop-bit period begins.
// - Reception starts only while the receive enable bit is one.
// - Load only if receive-done is zero and, with multiprocessor check, stop is one.
// - On failed load conditions buffer, stop bit and receive-done stay unchanged.
// - One interrupt request, when enabled, while either done flag is set.
// - Baud logic gets one pulse per rollover of the selected timer, every second one for the eight-bit timer without doubler.
// - Transmit and receive baud sources are chosen independently.
// - Transmit select field bits 3-2; code 00 is the eight-bit timer.
// - Receive select field bits 1-0; code 00 is the eight-bit timer.
// - Baud doubler resets to zero, halving the eight-bit timer rate.
// - Eight-bit timer bit rate is overflow rate over 32, or 16 doubled.
// - Frame-error flag sets on an invalid stop bit.
// - Overrun flag sets when a byte lands before the previous was read.
package ums_pkg;
  // Register offsets on the plain register port.
  localparam logic [3:0] UMS_OFS_CONTROL = 4'h0;
  localparam logic [3:0] UMS_OFS_DATA = 4'h1;
  localparam logic [3:0] UMS_OFS_STATUS = 4'h2;
  localparam logic [3:0] UMS_OFS_T1_RELOAD = 4'h3;
  localparam logic [3:0] UMS_OFS_T2_RELOAD_LO = 4'h4;
  localparam logic [3:0] UMS_OFS_T2_RELOAD_HI = 4'h5;
  localparam logic [3:0] UMS_OFS_T3_RELOAD_LO = 4'h6;
  localparam logic [3:0] UMS_OFS_T3_RELOAD_HI = 4'h7;
  localparam logic [3:0] UMS_OFS_T4_RELOAD_LO = 4'h8;
  localparam logic [3:0] UMS_OFS_T4_RELOAD_HI = 4'h9;
  localparam logic [3:0] UMS_OFS_TIMER_RUN = 4'hA;
  // Control register bit positions.
  localparam int UMS_CTL_RX_DONE = 0;
  localparam int UMS_CTL_TX_DONE = 1;
  localparam int UMS_CTL_STOP_BIT = 2;
  localparam int UMS_CTL_RX_EN = 4;
  localparam int UMS_CTL_MP_CHECK = 5;
  localparam int UMS_CTL_IRQ_EN = 7;
  // Status and baud select bit positions.
  localparam int UMS_STA_FRAME_ERR = 7;
  localparam int UMS_STA_OVERRUN = 6;
  localparam int UMS_STA_COLLISION = 5;
  localparam int UMS_STA_DOUBLER = 4;
  localparam int UMS_STA_TXSEL_LO = 2;
  localparam int UMS_STA_RXSEL_LO = 0;
  // Reset values.
  localparam logic [7:0] UMS_STATUS_RST = 8'h00;
  localparam logic [7:0] UMS_CONTROL_RST = 8'h00;
  localparam logic [7:0] UMS_TIMER8_MAX = 8'hFF;
  localparam logic [15:0] UMS_TIMER16_MAX = 16'hFFFF;
  // Baud pulses per bit time: sixteen samples per bit.
  localparam int UMS_OVERSAMPLE = 16;
  localparam logic [3:0] UMS_SAMPLE_MID = 4'h7;
  localparam logic [3:0] UMS_DATA_BITS = 4'h8;
  // Baud source codes.
  typedef enum logic [1:0] {
    UMS_SRC_T1 = 2'b00,
    UMS_SRC_T2 = 2'b01,
    UMS_SRC_T3 = 2'b10,
    UMS_SRC_T4 = 2'b11
  } ums_src_t;
endpackage : ums_pkg

// >>> src/ums_reload_timer.sv
`timescale 1ns/1ps
// Up-counting auto-reload timer that pulses once per rollover from all ones.
module ums_reload_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [WIDTH-1:0] reload_i,
  output logic ovf_o
);
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic ovf_nxt;
  wire logic at_max = (count_r == {WIDTH{1'b1}});

  // Rollover reloads the count and raises one pulse.
  assign count_nxt = !run_i ? count_r : (at_max ? reload_i : count_r + 1'b1);
  assign ovf_nxt = run_i && at_max;

  // Count register and overflow pulse.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= '0;
      ovf_o <= 1'b0;
    end else if (ce_i) begin
      count_r <= count_nxt;
      ovf_o <= ovf_nxt;
    end
  end
endmodule : ums_reload_timer

// >>> src/ums_uart.sv
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
// Variable-rate eight-bit serial port with four baud timers.
module ums_uart
  import ums_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic serial_rx_pin_i,
  output logic serial_tx_pin_o,
  output logic irq_o
);
  // Software-visible registers.
  logic [7:0] ctl_r;
  logic [7:0] sta_r;
  logic [7:0] rx_buf_r;
  logic [7:0] t1_reload_r;
  logic [15:0] t2_reload_r;
  logic [15:0] t3_reload_r;
  logic [15:0] t4_reload_r;
  logic [3:0] timer_run_r;
  logic unread_r;

  // Address decode.
  wire logic wr_ctl = wr_i && (addr_i == UMS_OFS_CONTROL);
  wire logic wr_data = wr_i && (addr_i == UMS_OFS_DATA);
  wire logic wr_sta = wr_i && (addr_i == UMS_OFS_STATUS);
  wire logic rd_data = rd_i && (addr_i == UMS_OFS_DATA);

  // Timers, one per baud source.
  logic [3:0] ovf;
  ums_reload_timer #(.WIDTH(8)) u_t1 (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .run_i(timer_run_r[0]),
    .reload_i(t1_reload_r), .ovf_o(ovf[0]));
  ums_reload_timer #(.WIDTH(16)) u_t2 (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .run_i(timer_run_r[1]),
    .reload_i(t2_reload_r), .ovf_o(ovf[1]));
  ums_reload_timer #(.WIDTH(16)) u_t3 (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .run_i(timer_run_r[2]),
    .reload_i(t3_reload_r), .ovf_o(ovf[2]));
  ums_reload_timer #(.WIDTH(16)) u_t4 (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .run_i(timer_run_r[3]),
    .reload_i(t4_reload_r), .ovf_o(ovf[3]));

  // Timer 1 halving: without the doubler only every second overflow counts.
  logic half_r;
  wire logic t1_tick = ovf[0] && (sta_r[UMS_STA_DOUBLER] || half_r);

  // Independent source selection per direction.
  wire logic [1:0] tx_sel = sta_r[UMS_STA_TXSEL_LO +: 2];
  wire logic [1:0] rx_sel = sta_r[UMS_STA_RXSEL_LO +: 2];
  wire logic [3:0] ticks = {ovf[3:1], t1_tick};
  wire logic tx_tick = ticks[tx_sel];
  wire logic rx_tick = ticks[rx_sel];

  // Receive pin synchroniser: a change counts once stages two and three agree.
  logic [2:0] rx_sync_r;
  logic rx_line_r;
  wire logic rx_line_nxt = (rx_sync_r[1] == rx_sync_r[2]) ? rx_sync_r[2] : rx_line_r;

  // Transmitter state.
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA = 4'b0100,
    TX_STOP = 4'b1000
  } ums_tx_state_t;
  ums_tx_state_t tx_state_r;
  logic [3:0] tx_sub_r;
  logic [3:0] tx_bit_r;
  logic [7:0] tx_shift_r;
  logic tx_pend_r;
  logic [7:0] tx_hold_r;
  wire logic tx_busy = (tx_state_r != TX_IDLE) || tx_pend_r;
  wire logic tx_bit_end = tx_tick && (tx_sub_r == 4'(UMS_OVERSAMPLE - 1));
  wire logic tx_last = (tx_bit_r == UMS_DATA_BITS - 4'h1);
  wire logic tx_done_set = (tx_state_r == TX_DATA) && tx_bit_end && tx_last;

  // Receiver state.
  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } ums_rx_state_t;
  ums_rx_state_t rx_state_r;
  logic [3:0] rx_sub_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_shift_r;
  wire logic rx_mid = rx_tick && (rx_sub_r == UMS_SAMPLE_MID);
  wire logic rx_stop_seen = (rx_state_r == RX_STOP) && rx_mid;
  wire logic rx_done_now = ctl_r[UMS_CTL_RX_DONE];
  wire logic rx_load_ok = !rx_done_now && (!ctl_r[UMS_CTL_MP_CHECK] || rx_line_r);
  wire logic rx_load = rx_stop_seen && rx_load_ok;
  wire logic frame_err_set = rx_stop_seen && !rx_line_r;
  wire logic overrun_set = rx_load && unread_r;
  wire logic collision_set = wr_data && tx_busy;

  // Next control value: hardware sets win over software clears.
  logic [7:0] ctl_nxt;
  always_comb begin
    ctl_nxt = wr_ctl ? wdata_i : ctl_r;
    if (tx_done_set) begin
      ctl_nxt[UMS_CTL_TX_DONE] = 1'b1;
    end
    if (rx_load) begin
      ctl_nxt[UMS_CTL_RX_DONE] = 1'b1;
      ctl_nxt[UMS_CTL_STOP_BIT] = rx_line_r;
    end
  end

  // Next status value: error flags are sticky until software writes zero.
  logic [7:0] sta_nxt;
  always_comb begin
    sta_nxt = wr_sta ? wdata_i : sta_r;
    if (frame_err_set) begin
      sta_nxt[UMS_STA_FRAME_ERR] = 1'b1;
    end
    if (overrun_set) begin
      sta_nxt[UMS_STA_OVERRUN] = 1'b1;
    end
    if (collision_set) begin
      sta_nxt[UMS_STA_COLLISION] = 1'b1;
    end
  end

  // Interrupt from the done flags only; error flags take no part.
  wire logic irq_nxt = ctl_nxt[UMS_CTL_IRQ_EN] &&
                       (ctl_nxt[UMS_CTL_TX_DONE] || ctl_nxt[UMS_CTL_RX_DONE]);

  // Read mux; unmapped addresses read zero.
  logic [7:0] rdata_nxt;
  always_comb begin
    unique case (addr_i)
      UMS_OFS_CONTROL: rdata_nxt = ctl_r;
      UMS_OFS_DATA: rdata_nxt = rx_buf_r;
      UMS_OFS_STATUS: rdata_nxt = sta_r;
      UMS_OFS_T1_RELOAD: rdata_nxt = t1_reload_r;
      UMS_OFS_T2_RELOAD_LO: rdata_nxt = t2_reload_r[7:0];
      UMS_OFS_T2_RELOAD_HI: rdata_nxt = t2_reload_r[15:8];
      UMS_OFS_T3_RELOAD_LO: rdata_nxt = t3_reload_r[7:0];
      UMS_OFS_T3_RELOAD_HI: rdata_nxt = t3_reload_r[15:8];
      UMS_OFS_T4_RELOAD_LO: rdata_nxt = t4_reload_r[7:0];
      UMS_OFS_T4_RELOAD_HI: rdata_nxt = t4_reload_r[15:8];
      UMS_OFS_TIMER_RUN: rdata_nxt = {4'h0, timer_run_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Register file, reload values and interrupt output.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r <= UMS_CONTROL_RST;
      sta_r <= UMS_STATUS_RST;
      t1_reload_r <= '0;
      t2_reload_r <= '0;
      t3_reload_r <= '0;
      t4_reload_r <= '0;
      timer_run_r <= '0;
      rdata_o <= '0;
      irq_o <= 1'b0;
      half_r <= 1'b0;
    end else if (ce_i) begin
      ctl_r <= ctl_nxt;
      sta_r <= sta_nxt;
      rdata_o <= rd_i ? rdata_nxt : 8'h00;
      irq_o <= irq_nxt;
      if (ovf[0]) begin
        half_r <= !half_r;
      end
      // Software programs the rate through the timer reloads.
      if (wr_i) begin
        unique case (addr_i)
          UMS_OFS_T1_RELOAD: t1_reload_r <= wdata_i;
          UMS_OFS_T2_RELOAD_LO: t2_reload_r[7:0] <= wdata_i;
          UMS_OFS_T2_RELOAD_HI: t2_reload_r[15:8] <= wdata_i;
          UMS_OFS_T3_RELOAD_LO: t3_reload_r[7:0] <= wdata_i;
          UMS_OFS_T3_RELOAD_HI: t3_reload_r[15:8] <= wdata_i;
          UMS_OFS_T4_RELOAD_LO: t4_reload_r[7:0] <= wdata_i;
          UMS_OFS_T4_RELOAD_HI: t4_reload_r[15:8] <= wdata_i;
          UMS_OFS_TIMER_RUN: timer_run_r <= wdata_i[3:0];
          default: ;
        endcase
      end
    end
  end

  // Unread marker: a new load sets it, a data read clears it, load wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unread_r <= 1'b0;
    end else if (ce_i) begin
      unread_r <= rx_load || (unread_r && !rd_data);
    end
  end

  // Transmitter: start, eight data bits LSB first, stop; sixteen ticks a bit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state_r <= TX_IDLE;
      tx_sub_r <= '0;
      tx_bit_r <= '0;
      tx_shift_r <= '0;
      tx_pend_r <= 1'b0;
      tx_hold_r <= '0;
      serial_tx_pin_o <= 1'b1;
    end else if (ce_i) begin
      if (wr_data && !tx_busy) begin
        tx_pend_r <= 1'b1;
        tx_hold_r <= wdata_i;
      end
      if (tx_tick) begin
        tx_sub_r <= tx_sub_r + 4'h1;
      end
      unique case (tx_state_r)
        TX_IDLE: begin
          // Start aligned to a baud tick so every bit lasts exactly sixteen.
          if (tx_pend_r && tx_tick) begin
            tx_state_r <= TX_START;
            tx_pend_r <= 1'b0;
            tx_shift_r <= tx_hold_r;
            tx_sub_r <= '0;
            tx_bit_r <= '0;
            serial_tx_pin_o <= 1'b0;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_state_r <= TX_DATA;
            serial_tx_pin_o <= tx_shift_r[0];
          end
        end
        TX_DATA: begin
          if (tx_bit_end) begin
            if (tx_last) begin
              tx_state_r <= TX_STOP;
              serial_tx_pin_o <= 1'b1;
            end else begin
              tx_bit_r <= tx_bit_r + 4'h1;
              tx_shift_r <= {1'b0, tx_shift_r[7:1]};
              serial_tx_pin_o <= tx_shift_r[1];
            end
          end
        end
        TX_STOP: begin
          if (tx_bit_end) begin
            tx_state_r <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // Receiver: start found on a falling line, bits sampled at mid-bit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sync_r <= 3'b111;
      rx_line_r <= 1'b1;
      rx_state_r <= RX_IDLE;
      rx_sub_r <= '0;
      rx_bit_r <= '0;
      rx_shift_r <= '0;
      rx_buf_r <= '0;
    end else if (ce_i) begin
      rx_sync_r <= {rx_sync_r[1:0], serial_rx_pin_i};
      rx_line_r <= rx_line_nxt;
      if (rx_tick) begin
        rx_sub_r <= rx_sub_r + 4'h1;
      end
      if (rx_load) begin
        rx_buf_r <= rx_shift_r;
      end
      unique case (rx_state_r)
        RX_IDLE: begin
          if (ctl_r[UMS_CTL_RX_EN] && rx_line_r && !rx_line_nxt) begin
            rx_state_r <= RX_START;
            rx_sub_r <= '0;
          end
        end
        RX_START: begin
          // A start that vanishes by mid-bit is a glitch.
          if (rx_mid) begin
            rx_state_r <= rx_line_r ? RX_IDLE : RX_DATA;
            rx_bit_r <= '0;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_shift_r <= {rx_line_r, rx_shift_r[7:1]};
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == UMS_DATA_BITS - 4'h1) begin
              rx_state_r <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_mid) begin
            rx_state_r <= RX_IDLE;
          end
        end
      endcase
    end
  end
endmodule : ums_uart

// >>> tb/ums_uart_monitor.sv
`timescale 1ns/1ps
// Port-level checks on register echo, read timing, interrupt and line framing.
module ums_uart_checker
  import ums_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic serial_rx_pin_i,
  input wire logic serial_tx_pin_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Strobes of the register port, and a write echoed by a later read.
  sequence s_wr(a);
    wr_i && ce_i && addr_i == a;
  endsequence
  sequence s_rd(a);
    rd_i && ce_i && addr_i == a;
  endsequence
  property p_echo(a, m);
    logic [7:0] v;
    (s_wr(a), v = wdata_i) ##2 s_rd(a) |=> (rdata_o & m) == (v & m);
  endproperty
  // Each assertion ties an output to its cause at the ports.
  a_reset_idle: assert property (
    $fell(rst_i) |-> serial_tx_pin_o && !irq_o && rdata_o == 8'h00)
    else $error("outputs not idle after reset");
  a_read_stands: assert property (rd_i ##1 !rd_i |=> rdata_o == 8'h00)
    else $error("read data held too long");
  a_unmapped_zero: assert property (rd_i && ce_i && addr_i > UMS_OFS_TIMER_RUN |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_irq_flags: assert property (
    s_rd(UMS_OFS_CONTROL) |=> irq_o == (rdata_o[UMS_CTL_IRQ_EN] &&
      (rdata_o[UMS_CTL_TX_DONE] || rdata_o[UMS_CTL_RX_DONE])))
    else $error("interrupt does not match done flags");
  a_sel_echo: assert property (p_echo(UMS_OFS_STATUS, 8'h1F))
    else $error("baud select fields not kept");
  a_ctl_echo: assert property (p_echo(UMS_OFS_CONTROL, 8'hB0))
    else $error("control enables not kept");
  a_start_len: assert property ($fell(serial_tx_pin_o) |-> !serial_tx_pin_o [*8])
    else $error("start bit too short");
  a_collision_set: assert property (
    (!serial_tx_pin_o && wr_i && ce_i && addr_i == UMS_OFS_DATA) ##2 s_rd(UMS_OFS_STATUS)
      |=> rdata_o[UMS_STA_COLLISION])
    else $error("collision flag not set");
endmodule : ums_uart_checker

bind ums_uart ums_uart_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .serial_rx_pin_i(serial_rx_pin_i), .serial_tx_pin_o(serial_tx_pin_o), .irq_o(irq_o));

// >>> tb/ums_remote.sv
`timescale 1ns/1ps
// Far-end serial device: frames bytes onto the line and decodes the returned line.
module ums_remote (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  int rx_cyc = 16;
  int got_count = 0;
  logic [7:0] got_byte = 8'h00;
  logic got_stop = 1'b0;
  initial line_o = 1'b1;
  // Start bit, eight data bits low first, then the given stop level.
  task automatic send(input logic [7:0] b, input logic s, input int cyc);
    logic [9:0] f;
    f = {s, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o <= f[i];
      repeat (cyc) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask : send
  // Samples each bit in its middle, timed from the start edge.
  always begin
    @(negedge line_i);
    repeat (rx_cyc / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (rx_cyc) @(posedge clk_i);
      got_byte[i] = line_i;
    end
    repeat (rx_cyc) @(posedge clk_i);
    got_stop = line_i;
    got_count++;
  end
endmodule : ums_remote

// >>> tb/tb_uart_mode1_with_baud_select.sv
`timescale 1ns/1ps
module tb_uart_mode1_with_baud_select
  import ums_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic serial_rx_pin_i;
  logic serial_tx_pin_o;
  logic irq_o;
  logic [7:0] r;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  ums_uart DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .serial_rx_pin_i(serial_rx_pin_i),
    .serial_tx_pin_o(serial_tx_pin_o), .irq_o(irq_o));
  ums_remote far_end (.clk_i(clk_i), .line_i(serial_tx_pin_o), .line_o(serial_rx_pin_i));
  // Clock and cycle counter; the counter also cuts a hang short.
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      final_report();
    end
  end
  // Register port cycles; each returns just after an edge.
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 r = rdata_o;
    @(posedge clk_i);
    #1;
  endtask : rd_reg
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wait_to(input int t);
    while (cycles < t) @(posedge clk_i);
    #1;
  endtask : wait_to
  // Reset values, an unmapped read and the control enables.
  task automatic t_reset();
    rd_reg(UMS_OFS_STATUS);
    chk("status_reset", UMS_STATUS_RST, r);
    rd_reg(UMS_OFS_CONTROL);
    chk("control_reset", 8'h00, r);
    rd_reg(4'hF);
    chk("unmapped", 8'h00, r);
    wr_reg(UMS_OFS_CONTROL, 8'hB0);
    rd_reg(UMS_OFS_CONTROL);
    chk("control_rw", 8'hB0, r);
    // A write while the clock enable is low must leave the register alone.
    ce_i <= 1'b0;
    wr_reg(UMS_OFS_CONTROL, 8'h00);
    ce_i <= 1'b1;
    rd_reg(UMS_OFS_CONTROL);
    chk("ce_freeze", 8'hB0, r);
    wr_reg(UMS_OFS_CONTROL, 8'h00);
  endtask : t_reset
  // Every select code in both fields, with the doubler both ways.
  task automatic t_select();
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {3'b000, 1'(i), 2'(i), 2'(3 - i)};
      wr_reg(UMS_OFS_STATUS, v);
      rd_reg(UMS_OFS_STATUS);
      chk("select", v, r);
    end
  endtask : t_select
  // One byte out from a chosen source, a colliding write, done flag timed to the frame.
  task automatic t_tx(input logic [1:0] sel, input logic dbl, input logic [7:0] b, input int cyc);
    int t0;
    int n;
    wr_reg(UMS_OFS_STATUS, {3'b000, dbl, sel, 2'b11});
    wr_reg(UMS_OFS_CONTROL, 8'h80);
    n = far_end.got_count;
    far_end.rx_cyc = cyc;
    wr_reg(UMS_OFS_DATA, b);
    while (serial_tx_pin_o) @(posedge clk_i);
    t0 = cycles;
    wr_reg(UMS_OFS_DATA, ~b);
    rd_reg(UMS_OFS_STATUS);
    chk("collision", {3'b001, dbl, sel, 2'b11}, r);
    wait_to(t0 + 8 * cyc + cyc / 2);
    rd_reg(UMS_OFS_CONTROL);
    chk("tx_done_early", 8'h80, r);
    wait_to(t0 + 9 * cyc + cyc / 2);
    rd_reg(UMS_OFS_CONTROL);
    chk("tx_done_stop", 8'h82, r);
    chk("irq_set", 8'h01, {7'b0, irq_o});
    wait_to(t0 + 11 * cyc);
    chk("tx_count", 8'(n + 1), 8'(far_end.got_count));
    chk("tx_byte", b, far_end.got_byte);
    chk("tx_stop", 8'h01, {7'b0, far_end.got_stop});
    wr_reg(UMS_OFS_CONTROL, 8'h80);
    chk("irq_clear", 8'h00, {7'b0, irq_o});
  endtask : t_tx
  // One byte in from the fourth timer, then flags, status and buffer.
  task automatic t_rx(input logic wc, input logic [7:0] ctl, input logic [7:0] b, input logic s,
      input logic [7:0] ec, input logic [7:0] es, input logic rdd, input logic [7:0] ed);
    if (wc) wr_reg(UMS_OFS_CONTROL, ctl);
    far_end.send(b, s, 48);
    repeat (8) @(posedge clk_i);
    #1;
    rd_reg(UMS_OFS_CONTROL);
    chk("rx_flags", ec, r & 8'h05);
    rd_reg(UMS_OFS_STATUS);
    chk("rx_status", es, r);
    if (rdd) begin
      rd_reg(UMS_OFS_DATA);
      chk("rx_data", ed, r);
    end
  endtask : t_rx
  task automatic final_report();
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // Main sequence: reset, registers, timers, transmit per source, receive cases.
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    t_reset();
    t_select();
    wr_reg(UMS_OFS_T1_RELOAD, 8'hFF);
    wr_reg(UMS_OFS_T2_RELOAD_LO, 8'hFF);
    wr_reg(UMS_OFS_T2_RELOAD_HI, 8'hFF);
    wr_reg(UMS_OFS_T3_RELOAD_LO, 8'hFE);
    wr_reg(UMS_OFS_T3_RELOAD_HI, 8'hFF);
    wr_reg(UMS_OFS_T4_RELOAD_LO, 8'hFD);
    wr_reg(UMS_OFS_T4_RELOAD_HI, 8'hFF);
    wr_reg(UMS_OFS_TIMER_RUN, 8'h0F);
    repeat (65600) @(posedge clk_i);
    #1;
    t_tx(2'b00, 1'b0, 8'hA5, 32);
    t_tx(2'b00, 1'b1, 8'h3C, 16);
    t_tx(2'b01, 1'b0, 8'h81, 16);
    t_tx(2'b10, 1'b0, 8'h5A, 32);
    t_tx(2'b11, 1'b0, 8'hC3, 48);
    wr_reg(UMS_OFS_STATUS, 8'h03);
    t_rx(1'b1, 8'h10, 8'h6E, 1'b1, 8'h05, 8'h03, 1'b0, 8'h00);
    t_rx(1'b0, 8'h10, 8'h91, 1'b1, 8'h05, 8'h03, 1'b1, 8'h6E);
    t_rx(1'b1, 8'h10, 8'h24, 1'b1, 8'h05, 8'h03, 1'b0, 8'h00);
    t_rx(1'b1, 8'h10, 8'hD7, 1'b1, 8'h05, 8'h43, 1'b1, 8'hD7);
    t_rx(1'b1, 8'h30, 8'h18, 1'b0, 8'h00, 8'hC3, 1'b1, 8'hD7);
    t_rx(1'b1, 8'h00, 8'h42, 1'b1, 8'h00, 8'hC3, 1'b1, 8'hD7);
    final_report();
  end
endmodule : tb_uart_mode1_with_baud_select
